/* hw/rtctmr_pkg.sv */
package rtctmr_pkg;
  localparam logic [7:0] CONTROL_TWO_OFFSET      = 8'h01;
  localparam logic [7:0] TIMER_CONTROL_OFFSET    = 8'h0e;
  localparam logic [7:0] TIMER_COUNTDOWN_OFFSET  = 8'h0f;
  localparam int         REPEAT_SELECT_BIT       = 4;
  localparam int         EVENT_FLAG_BIT          = 2;
  localparam int         IRQ_ENABLE_BIT          = 0;
  localparam int         RUN_ENABLE_BIT          = 7;
  localparam logic [7:0] CONTROL_TWO_RESET       = 8'h00;
  localparam logic [7:0] TIMER_CONTROL_RESET     = 8'h00;
  localparam logic [7:0] TIMER_COUNTDOWN_RESET   = 8'h00;
  localparam logic [1:0] SRC_4096HZ              = 2'h0;
  localparam logic [1:0] SRC_64HZ                = 2'h1;
  localparam logic [1:0] SRC_SECONDS             = 2'h2;
  localparam logic [1:0] SRC_MINUTES             = 2'h3;
  // Host register offsets (byte addresses on AHB-Lite).
  localparam logic [7:0] HOST_CMD_OFFSET         = 8'h00;
  localparam logic [7:0] HOST_WDATA_OFFSET       = 8'h04;
  localparam logic [7:0] HOST_STATUS_OFFSET      = 8'h08;
  localparam logic [7:0] HOST_RDATA_OFFSET       = 8'h0c;
  localparam logic [7:0] HOST_IRQ_OFFSET         = 8'h10;
  localparam logic [31:0] HOST_RESET_VALUE       = 32'h0000_0000;
endpackage

/* hw/rtctmr_if.sv */
interface rtctmr_if;
  logic       wr_en;
  logic       rd_en;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       irq_n_o;
  logic       irq_n_oe_n;
  logic       irq_n_wire;
  assign irq_n_wire = irq_n_oe_n ? 1'b1 : irq_n_o;
  modport device (input wr_en, input rd_en, input addr, input wdata, output rdata, output irq_n_o,
                  output irq_n_oe_n);
  modport host (output wr_en, output rd_en, output addr, output wdata, input rdata, input irq_n_wire);
endinterface

/* hw/rtctmr_device.sv */
module rtctmr_device #(
  parameter int CLK_HZ = 125_000_000
) (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic seconds_update,
  input  wire logic minutes_update,
  rtctmr_if.device  bus
);
  import rtctmr_pkg::*;

  localparam real TICK_4096_US  = 244.14;
  localparam real TICK_64_MS    = 15.625;
  localparam real RTN_SHORT_US  = 122.0;
  localparam real RTN_MID_MS    = 7.813;
  localparam int  DIV_4096 = int'(TICK_4096_US * CLK_HZ / 1.0e6);
  localparam int  DIV_64   = int'(TICK_64_MS * CLK_HZ / 1.0e3);
  localparam int  RTN_SHORT = int'(RTN_SHORT_US * CLK_HZ / 1.0e6);
  localparam int  RTN_FAST  = DIV_4096;
  localparam int  RTN_MID   = int'(RTN_MID_MS * CLK_HZ / 1.0e3);
  localparam int  RTN_LONG  = DIV_64;

  logic [7:0]  control_two_reg;
  logic [7:0]  timer_control_reg;
  logic [7:0]  preset_reg;
  logic [7:0]  count_reg;
  logic [31:0] div_a_reg;
  logic [31:0] div_b_reg;
  logic [31:0] rtn_reg;
  logic        run_d_reg;
  logic        sec_s1_reg, sec_s2_reg, sec_s3_reg;
  logic        min_s1_reg, min_s2_reg, min_s3_reg;
  logic        irq_low_reg;
  logic [7:0]  rdata_reg;
  logic        tick_4096, tick_64, tick_sel, event_hit, run;

  assign run       = timer_control_reg[RUN_ENABLE_BIT];
  assign tick_4096 = (div_a_reg == 32'(DIV_4096 - 1));
  assign tick_64   = (div_b_reg == 32'(DIV_64 - 1));

  // Slow sources follow the calendar edges, so the first tick may come early.
  always_ff @(posedge clk) begin
    sec_s1_reg <= seconds_update;
    sec_s2_reg <= sec_s1_reg;
    sec_s3_reg <= sec_s2_reg;
    min_s1_reg <= minutes_update;
    min_s2_reg <= min_s1_reg;
    min_s3_reg <= min_s2_reg;
  end

  always_comb begin
    case (timer_control_reg[1:0])
      SRC_4096HZ: tick_sel = tick_4096;
      SRC_64HZ:   tick_sel = tick_64;
      SRC_SECONDS: tick_sel = sec_s2_reg & ~sec_s3_reg;
      default:    tick_sel = min_s2_reg & ~min_s3_reg;
    endcase
  end

  assign event_hit = run && tick_sel && count_reg == 8'h01;

  // Dividers restart on start; a divider at its last count in the start cycle still ticks in that cycle.
  always_ff @(posedge clk) begin
    if (!reset_n || (run && !run_d_reg) || tick_4096) begin
      div_a_reg <= 32'h0000_0000;
    end else begin
      div_a_reg <= div_a_reg + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n || (run && !run_d_reg) || tick_64) begin
      div_b_reg <= 32'h0000_0000;
    end else begin
      div_b_reg <= div_b_reg + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      run_d_reg <= 1'b0;
    end else begin
      run_d_reg <= run;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      timer_control_reg <= TIMER_CONTROL_RESET;
    end else if (bus.wr_en && bus.addr == TIMER_CONTROL_OFFSET) begin
      timer_control_reg <= {bus.wdata[7], 5'h00, bus.wdata[1:0]};
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      control_two_reg <= CONTROL_TWO_RESET;
    end else begin
      if (bus.wr_en && bus.addr == CONTROL_TWO_OFFSET) begin
        control_two_reg[REPEAT_SELECT_BIT] <= bus.wdata[REPEAT_SELECT_BIT];
        control_two_reg[IRQ_ENABLE_BIT]    <= bus.wdata[IRQ_ENABLE_BIT];
        if (!bus.wdata[EVENT_FLAG_BIT]) begin
          control_two_reg[EVENT_FLAG_BIT] <= 1'b0;
        end
      end
      if (event_hit) begin
        control_two_reg[EVENT_FLAG_BIT] <= 1'b1;
      end
    end
  end

  // Preset writes are accepted while stopped; the counter follows the preset then.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      preset_reg <= TIMER_COUNTDOWN_RESET;
      count_reg  <= TIMER_COUNTDOWN_RESET;
    end else if (bus.wr_en && bus.addr == TIMER_COUNTDOWN_OFFSET && !run) begin
      preset_reg <= bus.wdata;
      count_reg  <= bus.wdata;
    end else if (run && tick_sel) begin
      if (count_reg == 8'h01) begin
        count_reg <= preset_reg;
      end else if (count_reg != 8'h00) begin
        count_reg <= count_reg - 8'h01;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rtn_reg <= 32'h0000_0000;
    end else if (event_hit && control_two_reg[REPEAT_SELECT_BIT]) begin
      case (timer_control_reg[1:0])
        SRC_4096HZ: rtn_reg <= (preset_reg == 8'h01) ? 32'(RTN_SHORT) : 32'(RTN_FAST);
        SRC_64HZ:   rtn_reg <= (preset_reg == 8'h01) ? 32'(RTN_MID) : 32'(RTN_LONG);
        default:    rtn_reg <= 32'(RTN_LONG);
      endcase
    end else if (rtn_reg != 32'h0000_0000) begin
      rtn_reg <= rtn_reg - 32'h0000_0001;
    end
  end

  // Level mode follows the flag and enable, so enabling late pulls low at once.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      irq_low_reg <= 1'b0;
    end else if (control_two_reg[REPEAT_SELECT_BIT]) begin
      irq_low_reg <= control_two_reg[IRQ_ENABLE_BIT] && run &&
                     (event_hit || rtn_reg > 32'h0000_0001);
    end else begin
      irq_low_reg <= control_two_reg[IRQ_ENABLE_BIT] && (control_two_reg[EVENT_FLAG_BIT] || event_hit) &&
                     !(bus.wr_en && bus.addr == CONTROL_TWO_OFFSET && !bus.wdata[EVENT_FLAG_BIT]
                       && !event_hit);
    end
  end

  assign bus.irq_n_o    = 1'b0;
  assign bus.irq_n_oe_n = ~irq_low_reg;

  // Counter reads are not held; software compares two reads.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rdata_reg <= 8'h00;
    end else if (bus.rd_en) begin
      if (bus.addr == CONTROL_TWO_OFFSET) begin
        rdata_reg <= control_two_reg;
      end else if (bus.addr == TIMER_CONTROL_OFFSET) begin
        rdata_reg <= timer_control_reg;
      end else if (bus.addr == TIMER_COUNTDOWN_OFFSET) begin
        rdata_reg <= count_reg;
      end else begin
        rdata_reg <= 8'h00;
      end
    end
  end

  assign bus.rdata = rdata_reg;
endmodule

/* hw/rtctmr_host.sv */
// Host side: AHB-Lite slave turning register writes into device accesses.
module rtctmr_host (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  rtctmr_if.host           dev
);
  import rtctmr_pkg::*;

  logic        wr_pend_reg;
  logic [7:0]  wr_addr_reg;
  logic [31:0] cmd_reg;
  logic [31:0] wdata_reg;
  logic [7:0]  dev_rdata_reg;
  logic        busy_reg;
  logic        rd_wait_reg;
  logic [1:0]  irq_s_reg;
  logic        wr_en_reg;
  logic        rd_en_reg;
  logic [31:0] hrdata_reg;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
    end else begin
      wr_pend_reg <= hsel && hready && htrans[1] && hwrite;
      if (hsel && hready && htrans[1]) begin
        wr_addr_reg <= haddr[7:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    irq_s_reg <= {irq_s_reg[0], dev.irq_n_wire};
  end

  // Command word: bit 8 starts a read, bit 9 a write, low byte is device address.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cmd_reg   <= HOST_RESET_VALUE;
      wdata_reg <= HOST_RESET_VALUE;
      wr_en_reg <= 1'b0;
      rd_en_reg <= 1'b0;
      busy_reg  <= 1'b0;
      rd_wait_reg <= 1'b0;
      dev_rdata_reg <= 8'h00;
    end else begin
      wr_en_reg <= 1'b0;
      rd_en_reg <= 1'b0;
      rd_wait_reg <= rd_en_reg;
      if (rd_wait_reg) begin
        dev_rdata_reg <= dev.rdata;
        busy_reg <= 1'b0;
      end
      if (wr_pend_reg && wr_addr_reg == HOST_WDATA_OFFSET) begin
        wdata_reg <= hwdata;
      end else if (wr_pend_reg && wr_addr_reg == HOST_CMD_OFFSET) begin
        cmd_reg <= hwdata;
        wr_en_reg <= hwdata[9];
        rd_en_reg <= hwdata[8];
        busy_reg  <= hwdata[8];
      end
    end
  end

  assign dev.wr_en = wr_en_reg;
  assign dev.rd_en = rd_en_reg;
  assign dev.addr  = cmd_reg[7:0];
  assign dev.wdata = wdata_reg[7:0];

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      hrdata_reg <= HOST_RESET_VALUE;
    end else if (hsel && hready && htrans[1] && !hwrite) begin
      if (haddr[7:0] == HOST_CMD_OFFSET) begin
        hrdata_reg <= cmd_reg;
      end else if (haddr[7:0] == HOST_WDATA_OFFSET) begin
        hrdata_reg <= wdata_reg;
      end else if (haddr[7:0] == HOST_STATUS_OFFSET) begin
        hrdata_reg <= {31'h0000_0000, busy_reg};
      end else if (haddr[7:0] == HOST_RDATA_OFFSET) begin
        hrdata_reg <= {24'h00_0000, dev_rdata_reg};
      end else if (haddr[7:0] == HOST_IRQ_OFFSET) begin
        hrdata_reg <= {31'h0000_0000, ~irq_s_reg[1]};
      end else begin
        hrdata_reg <= HOST_RESET_VALUE;
      end
    end
  end

  assign hrdata = hrdata_reg;
endmodule

/* test/rtctmr_chk.sv */
module rtctmr_chk (
  input wire logic       clk,
  input wire logic       reset_n,
  input wire logic       wr_en,
  input wire logic       rd_en,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic       irq_n_o,
  input wire logic       irq_n_oe_n
);
  import rtctmr_pkg::*;
  // Longest release pulse at the bench clock rate, with margin.
  localparam int REL_MAX = 700;
  logic        c2_wr;
  logic        en_reg;
  logic        rep_reg;
  logic        run_reg;
  logic [15:0] low_reg;
  assign c2_wr = wr_en && addr == CONTROL_TWO_OFFSET;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      en_reg  <= 1'b0;
      rep_reg <= 1'b0;
      run_reg <= 1'b0;
    end else if (wr_en) begin
      if (c2_wr) begin
        en_reg  <= wdata[IRQ_ENABLE_BIT];
        rep_reg <= wdata[REPEAT_SELECT_BIT];
      end
      if (addr == TIMER_CONTROL_OFFSET) begin
        run_reg <= wdata[RUN_ENABLE_BIT];
      end
    end
  end
  always_ff @(posedge clk) begin
    low_reg <= (!reset_n || irq_n_oe_n) ? 16'h0000 : low_reg + 16'h0001;
  end
  reset_hiz_a: assert property (@(posedge clk) !reset_n |=> irq_n_oe_n)
    else $error("pin driven after reset");
  drive_low_a: assert property (@(posedge clk) disable iff (!reset_n) irq_n_o == 1'b0)
    else $error("open drain drives high");
  read_hold_a: assert property (@(posedge clk) disable iff (!reset_n) !rd_en |=> $stable(rdata))
    else $error("read data moved without a read");
  flag_clear_a: assert property (@(posedge clk) disable iff (!reset_n)
    c2_wr && !wdata[REPEAT_SELECT_BIT] && !wdata[EVENT_FLAG_BIT] |-> ##[1:2] irq_n_oe_n)
    else $error("flag clear kept pin low");
  irq_mask_a: assert property (@(posedge clk) disable iff (!reset_n)
    c2_wr && !wdata[IRQ_ENABLE_BIT] |-> ##[1:2] irq_n_oe_n) else $error("disabled pin still low");
  fall_enabled_a: assert property (@(posedge clk) disable iff (!reset_n)
    $fell(irq_n_oe_n) |-> en_reg || $past(en_reg)) else $error("pin fell while disabled");
  fall_cause_a: assert property (@(posedge clk) disable iff (!reset_n)
    $fell(irq_n_oe_n) |-> run_reg || $past(wr_en) || $past(wr_en, 2)) else $error("event while stopped");
  level_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
    !rep_reg && !irq_n_oe_n && !wr_en && !$past(wr_en) |=> !irq_n_oe_n) else $error("level pin let go");
  pulse_len_a: assert property (@(posedge clk) disable iff (!reset_n)
    rep_reg |-> low_reg <= REL_MAX) else $error("repeated pulse too long");
  cover property (@(posedge clk) $fell(irq_n_oe_n) && rep_reg);
  cover property (@(posedge clk) $fell(irq_n_oe_n) && !rep_reg);
  cover property (@(posedge clk) c2_wr && !wdata[EVENT_FLAG_BIT]);
endmodule

/* test/rtctmr_tb.sv */
module rtctmr_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import rtctmr_pkg::*;
  localparam int CLK_HZ = 40_960;
  logic        clk, reset_n, seconds_update, minutes_update, hsel, hwrite, hreadyout, hresp;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, r;
  int          failures, tests_run, t, seed, w[3];
  logic [7:0]  pre;
  rtctmr_if bus_if ();
  rtctmr_device #(.CLK_HZ(CLK_HZ)) rtctmr_device_i (.clk(clk), .reset_n(reset_n),
    .seconds_update(seconds_update), .minutes_update(minutes_update), .bus(bus_if));
  rtctmr_host rtctmr_host_i (.clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .dev(bus_if));
  rtctmr_chk rtctmr_chk_i (.clk(clk), .reset_n(reset_n), .wr_en(bus_if.wr_en), .rd_en(bus_if.rd_en),
    .addr(bus_if.addr), .wdata(bus_if.wdata), .rdata(bus_if.rdata), .irq_n_o(bus_if.irq_n_o),
    .irq_n_oe_n(bus_if.irq_n_oe_n));
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  // Release time in bench cycles for a source and preset; rounding may move it by one cycle.
  function automatic int rel_cycles(input logic [1:0] src, input logic [7:0] n);
    real us;
    if (src == SRC_4096HZ) begin
      us = (n == 8'd1) ? 122.0 : 244.0;
    end else if (src == SRC_64HZ && n == 8'd1) begin
      us = 7813.0;
    end else begin
      us = 15625.0;
    end
    return int'(us * CLK_HZ / 1.0e6);
  endfunction
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h00_0000, a};
    hwrite <= wr;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic dev_wr(input logic [7:0] a, input logic [7:0] d);
    ahb(1'b1, HOST_WDATA_OFFSET, {24'h00_0000, d}, r);
    ahb(1'b1, HOST_CMD_OFFSET, {24'h00_0002, a}, r);
  endtask
  task automatic dev_rd(input logic [7:0] a, output logic [31:0] q);
    ahb(1'b1, HOST_CMD_OFFSET, {24'h00_0001, a}, q);
    q = 32'h0000_0001;
    for (int i = 0; i < 8 && q[0]; i++) ahb(1'b0, HOST_STATUS_OFFSET, 32'h0000_0000, q);
    ahb(1'b0, HOST_RDATA_OFFSET, 32'h0000_0000, q);
  endtask
  task automatic wait_pin(input logic lv, output int n);
    n = 0;
    while (bus_if.irq_n_wire !== lv && n < 5000) begin
      @(negedge clk);
      n++;
    end
  endtask
  // Stop, wait for the pin, then configure and preset while stopped.
  task automatic start(input logic [7:0] ctl, input logic [7:0] n, input logic [1:0] src);
    dev_wr(TIMER_CONTROL_OFFSET, 8'h00);
    dev_wr(CONTROL_TWO_OFFSET, 8'h00);
    wait_pin(1'b1, t);
    dev_wr(CONTROL_TWO_OFFSET, ctl);
    dev_wr(TIMER_COUNTDOWN_OFFSET, n);
    dev_wr(TIMER_CONTROL_OFFSET, {6'h20, src});
  endtask
  task automatic tick(input int s);
    repeat (4 + ($random(seed) & 15)) @(posedge clk);
    seconds_update <= s == 2;
    minutes_update <= s == 3;
    repeat (4) @(posedge clk);
    {seconds_update, minutes_update} <= 2'h0;
    repeat (20) @(negedge clk);
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    repeat (60000) @(posedge clk);
    failures++;
    wrap_up();
  end
  initial begin
    {reset_n, seconds_update, minutes_update, hsel, hwrite, htrans} = '0;
    {haddr, hwdata} = '0;
    hsize = 3'h2;
    seed = 40;
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    ahb(1'b0, 8'h14, 32'h0000_0000, r);
    chk("unmapped", HOST_RESET_VALUE, r);
    chk("okay response", 0, hresp);
    dev_rd(TIMER_CONTROL_OFFSET, r);
    chk("timer_control", {24'h00_0000, TIMER_CONTROL_RESET}, r);
    for (int i = 0; i < 3; i++) begin
      pre = (i == 1) ? 8'd2 + 8'($random(seed) & 7) : 8'd1;
      start(8'h11, pre, i == 2 ? SRC_64HZ : SRC_4096HZ);
      wait_pin(1'b0, t);
      wait_pin(1'b1, w[i]);
      wait_pin(1'b0, t);
      chk("period", (i == 2 ? CLK_HZ / 64 : CLK_HZ / 4096) * pre, w[i] + t);
      chk("pulse", 1, (w[i] - rel_cycles(i == 2 ? SRC_64HZ : SRC_4096HZ, pre)) inside {[-1:1]});
    end
    chk("release", 1, w[0] < w[1]);
    start(8'h11, 8'd255, SRC_4096HZ);
    wait_pin(1'b0, t);
    wait_pin(1'b1, w[0]);
    wait_pin(1'b0, t);
    chk("long period", 255 * (CLK_HZ / 4096), w[0] + t);
    start(8'h01, 8'd20, SRC_4096HZ);
    wait_pin(1'b0, t);
    dev_rd(CONTROL_TWO_OFFSET, r);
    chk("flag", 1, r[EVENT_FLAG_BIT]);
    dev_rd(TIMER_COUNTDOWN_OFFSET, r);
    chk("live count", 1, r >= 1 && r <= 20);
    ahb(1'b0, HOST_IRQ_OFFSET, 32'h0000_0000, r);
    chk("pin held", 1, r[0]);
    dev_wr(CONTROL_TWO_OFFSET, 8'h01);
    wait_pin(1'b1, t);
    chk("cleared", 1, t < 8);
    wait_pin(1'b0, t);
    chk("next event", 1, t > 0 && t <= 200);
    dev_wr(CONTROL_TWO_OFFSET, 8'h04);
    wait_pin(1'b1, t);
    chk("masked", 1, t < 8);
    dev_wr(TIMER_CONTROL_OFFSET, 8'h00);
    repeat (300) @(posedge clk);
    dev_rd(CONTROL_TWO_OFFSET, r);
    chk("flag kept", 1, r[EVENT_FLAG_BIT]);
    dev_wr(CONTROL_TWO_OFFSET, 8'h05);
    wait_pin(1'b0, t);
    chk("pending", 1, t < 8);
    for (int s = 2; s < 4; s++) begin
      start(8'h01, 8'd2, s[1:0]);
      tick(s);
      chk("one tick", 1, bus_if.irq_n_wire);
      tick(s);
      chk("two ticks", 0, bus_if.irq_n_wire);
    end
    wrap_up();
  end
endmodule
